/* File: hw/bvs_shifter.sv */
// video shifter end: plane words to palette-mapped pixels
`timescale 1ns/1ps
module bvs_shifter
  import bvs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link to memory controller
  bvs_link_if.shifter link,
  // mode and status
  input wire logic [1:0] res_sel,
  input wire logic mono_monitor_detect,
  output logic mono_attached,
  // video outputs
  output logic [LEVEL_W-1:0] red_out,
  output logic [LEVEL_W-1:0] green_out,
  output logic [LEVEL_W-1:0] blue_out,
  output logic mono_out
);
  logic [PAL_ENTRY_W-1:0] pal_ff [PAL_ENTRIES];
  logic [PAL_ENTRY_W-1:0] nxt_pal [PAL_ENTRIES];
  logic [WORD_W-1:0] stage_ff [PLANES_MAX];
  logic [WORD_W-1:0] nxt_stage [PLANES_MAX];
  logic [WORD_W-1:0] shift_ff [PLANES_MAX];
  logic [WORD_W-1:0] nxt_shift [PLANES_MAX];
  logic [1:0] plane_cnt_ff, nxt_plane_cnt;
  logic [BIT_CNT_W-1:0] bit_cnt_ff, nxt_bit_cnt;
  logic run_ff, nxt_run;
  logic ready_ff, nxt_ready;
  logic det_s1_ff, det_s2_ff;
  logic [LEVEL_W-1:0] red_ff, green_ff, blue_ff, nxt_red, nxt_green, nxt_blue;
  logic mono_ff, nxt_mono, attached_ff, nxt_attached;
  bvs_res_t res;
  logic [2:0] nplanes;
  logic [PAL_IDX_W-1:0] idx;
  logic [PAL_ENTRY_W-1:0] entry;
  logic pix_bit;

  assign res = bvs_res_t'(res_sel);
  assign nplanes = planes_of(res);

  // pixel index from the current msb of shift words 0 to 3 in low res and 0 to 1 in medium; zero in high
  always_comb begin
    idx = '0;
    unique case (res)
      BVS_RES_LOW: idx = {shift_ff[3][WORD_W-1], shift_ff[2][WORD_W-1],
                          shift_ff[1][WORD_W-1], shift_ff[0][WORD_W-1]};
      BVS_RES_MED: idx = {2'b00, shift_ff[1][WORD_W-1], shift_ff[0][WORD_W-1]};
      default: idx = '0;
    endcase
  end
  assign entry = pal_ff[idx];
  assign pix_bit = shift_ff[0][WORD_W-1];

  // palette writes from the controller
  always_comb begin
    for (int i = 0; i < PAL_ENTRIES; i++) begin
      nxt_pal[i] = pal_ff[i];
    end
    if (link.palette_write_select) begin
      nxt_pal[link.pal_addr] = link.data[PAL_ENTRY_W-1:0];
    end
  end

  // word staging and serialisation
  always_comb begin
    for (int i = 0; i < PLANES_MAX; i++) begin
      nxt_stage[i] = stage_ff[i];
      nxt_shift[i] = shift_ff[i];
    end
    nxt_plane_cnt = plane_cnt_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_run = run_ff;
    nxt_ready = ready_ff;
    if (run_ff) begin
      for (int i = 0; i < PLANES_MAX; i++) begin
        nxt_shift[i] = {shift_ff[i][WORD_W-2:0], 1'b0};
      end
      nxt_bit_cnt = bit_cnt_ff + 4'h1;
      if (bit_cnt_ff == LAST_BIT) begin
        nxt_run = 1'b0;
      end
    end
    // next group waits until the current sixteen pixels are out
    if (ready_ff && (!run_ff || bit_cnt_ff == LAST_BIT)) begin
      for (int i = 0; i < PLANES_MAX; i++) begin
        nxt_shift[i] = stage_ff[i];
      end
      nxt_run = 1'b1;
      nxt_bit_cnt = '0;
      nxt_ready = 1'b0;
    end
    // words outside a visible line are ignored
    if (link.shift_load_strobe && link.line_visible_strobe) begin
      nxt_stage[plane_cnt_ff] = link.data;
      if ({1'b0, plane_cnt_ff} == nplanes - 3'h1) begin
        nxt_plane_cnt = '0;
        nxt_ready = 1'b1;
      end else begin
        nxt_plane_cnt = plane_cnt_ff + 2'h1;
      end
    end
    // vsync drops any partial group and stops output
    if (link.vsync) begin
      nxt_plane_cnt = '0;
      nxt_ready = 1'b0;
      nxt_run = 1'b0;
    end
  end

  // output stage
  always_comb begin
    nxt_red = '0;
    nxt_green = '0;
    nxt_blue = '0;
    nxt_mono = 1'b0;
    nxt_attached = ~det_s2_ff;
    if (run_ff && !link.blank) begin
      if (res == BVS_RES_HIGH) begin
        nxt_mono = pix_bit ^ pal_ff[0][INVERT_BIT];
      end else begin
        nxt_red = entry[RED_LSB +: LEVEL_W];
        nxt_green = entry[GRN_LSB +: LEVEL_W];
        nxt_blue = entry[BLU_LSB +: LEVEL_W];
      end
    end
  end

  // palette registers
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < PAL_ENTRIES; i++) begin
        pal_ff[i] <= PAL_RESET;
      end
    end else begin
      pal_ff <= nxt_pal;
    end
  end

  // staging and serialiser registers
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < PLANES_MAX; i++) begin
        stage_ff[i] <= '0;
        shift_ff[i] <= '0;
      end
      plane_cnt_ff <= '0;
      bit_cnt_ff <= '0;
      run_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else begin
      stage_ff <= nxt_stage;
      shift_ff <= nxt_shift;
      plane_cnt_ff <= nxt_plane_cnt;
      bit_cnt_ff <= nxt_bit_cnt;
      run_ff <= nxt_run;
      ready_ff <= nxt_ready;
    end
  end

  // monitor detect pin synchroniser
  always_ff @(posedge clk) begin
    det_s1_ff <= mono_monitor_detect;
    det_s2_ff <= det_s1_ff;
  end

  // output registers
  always_ff @(posedge clk) begin
    if (rst) begin
      red_ff <= '0;
      green_ff <= '0;
      blue_ff <= '0;
      mono_ff <= 1'b0;
      attached_ff <= 1'b0;
    end else begin
      red_ff <= nxt_red;
      green_ff <= nxt_green;
      blue_ff <= nxt_blue;
      mono_ff <= nxt_mono;
      attached_ff <= nxt_attached;
    end
  end

  assign red_out = red_ff;
  assign green_out = green_ff;
  assign blue_out = blue_ff;
  assign mono_out = mono_ff;
  assign mono_attached = attached_ff;
endmodule // bvs_shifter

/* File: hw/bvs_pkg.sv */
// shared constants and types for the bitplane video shifter
package bvs_pkg;
  localparam int WORD_W = 16;
  localparam int PAL_ENTRIES = 16;
  localparam int PAL_IDX_W = 4;
  localparam int LEVEL_W = 3;
  localparam int PLANES_MAX = 4;
  localparam int FB_BYTES = 32768;
  localparam int FB_ALIGN_BYTES = 256;
  localparam int ADDR_W = 23;
  localparam int FB_WORDS = FB_BYTES / 2;
  localparam int PAL_ENTRY_W = 3 * LEVEL_W;
  localparam logic [ADDR_W-1:0] BASE_ALIGN_MASK = 23'h0000ff;
  localparam logic [PAL_ENTRY_W-1:0] PAL_RESET = 9'h000;
  localparam int RED_LSB = 6;
  localparam int GRN_LSB = 3;
  localparam int BLU_LSB = 0;
  localparam int INVERT_BIT = 0;
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hf;

  // display resolutions
  typedef enum logic [1:0] {
    BVS_RES_LOW = 2'b00,
    BVS_RES_MED = 2'b01,
    BVS_RES_HIGH = 2'b10
  } bvs_res_t;

  // fetch sequencer on the memory side
  typedef enum logic [1:0] {
    BVS_F_IDLE = 2'b00,
    BVS_F_LOAD = 2'b01,
    BVS_F_WAIT = 2'b11
  } bvs_fetch_t;

  function automatic logic [2:0] planes_of(input bvs_res_t res);
    unique case (res)
      BVS_RES_LOW: planes_of = 3'h4;
      BVS_RES_MED: planes_of = 3'h2;
      default: planes_of = 3'h1;
    endcase
  endfunction
endpackage

/* File: hw/bvs_link_if.sv */
// link between memory controller end and video shifter end
`timescale 1ns/1ps
interface bvs_link_if;
  import bvs_pkg::*;
  logic [WORD_W-1:0] data;
  logic shift_load_strobe;
  logic palette_write_select;
  logic [PAL_IDX_W-1:0] pal_addr;
  logic line_visible_strobe;
  logic blank;
  logic vsync;

  modport shifter (
    input data, shift_load_strobe, palette_write_select, pal_addr,
    input line_visible_strobe, blank, vsync
  );
  modport memctl (
    output data, shift_load_strobe, palette_write_select, pal_addr,
    output line_visible_strobe, blank, vsync
  );
endinterface

/* File: hw/bvs_memctl.sv */
// memory controller end: display fetch, load strobes, palette writes
`timescale 1ns/1ps
module bvs_memctl
  import bvs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // software side
  input wire logic base_wr,
  input wire logic [ADDR_W-1:0] base_addr,
  input wire logic pal_wr,
  input wire logic [PAL_IDX_W-1:0] pal_index,
  input wire logic [PAL_ENTRY_W-1:0] pal_value,
  // timing strobes from system timing
  input wire logic disp_enable,
  input wire logic disp_blank,
  input wire logic disp_vsync,
  // display memory port
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_rd,
  input wire logic [WORD_W-1:0] mem_rdata,
  input wire logic mem_valid,
  // link to shifter
  bvs_link_if.memctl link
);
  logic [ADDR_W-1:0] base_ff, nxt_base, addr_ff, nxt_addr;
  logic [WORD_W-1:0] data_ff, nxt_data;
  logic load_ff, nxt_load, palsel_ff, nxt_palsel, rd_ff, nxt_rd;
  logic [PAL_IDX_W-1:0] paddr_ff, nxt_paddr;
  logic de_ff, blank_ff, vs_ff;
  bvs_fetch_t st_ff, nxt_st;

  always_comb begin
    nxt_base = base_ff;
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    nxt_load = 1'b0;
    nxt_palsel = 1'b0;
    nxt_paddr = paddr_ff;
    nxt_rd = 1'b0;
    nxt_st = st_ff;
    if (base_wr) begin
      nxt_base = base_addr & ~BASE_ALIGN_MASK;
    end
    unique case (st_ff)
      BVS_F_IDLE: begin
        if (disp_enable) begin
          nxt_rd = 1'b1;
          nxt_st = BVS_F_WAIT;
        end
      end
      BVS_F_WAIT: begin
        nxt_rd = ~mem_valid;
        if (mem_valid) begin
          nxt_data = mem_rdata;
          // a word that lands after the line ended is dropped
          nxt_load = disp_enable;
          nxt_addr = addr_ff + 23'h000002;
          nxt_st = BVS_F_LOAD;
        end
      end
      BVS_F_LOAD: nxt_st = BVS_F_IDLE;
      default: nxt_st = BVS_F_IDLE;
    endcase
    if (pal_wr && st_ff != BVS_F_WAIT) begin
      nxt_palsel = 1'b1;
      nxt_paddr = pal_index;
      nxt_data = {{(WORD_W-PAL_ENTRY_W){1'b0}}, pal_value};
    end
    if (disp_vsync) begin
      nxt_addr = base_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      base_ff <= '0;
      addr_ff <= '0;
      data_ff <= '0;
      load_ff <= 1'b0;
      palsel_ff <= 1'b0;
      paddr_ff <= '0;
      rd_ff <= 1'b0;
      st_ff <= BVS_F_IDLE;
      de_ff <= 1'b0;
      blank_ff <= 1'b1;
      vs_ff <= 1'b0;
    end else begin
      base_ff <= nxt_base;
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
      load_ff <= nxt_load;
      palsel_ff <= nxt_palsel;
      paddr_ff <= nxt_paddr;
      rd_ff <= nxt_rd;
      st_ff <= nxt_st;
      de_ff <= disp_enable;
      blank_ff <= disp_blank;
      vs_ff <= disp_vsync;
    end
  end

  assign mem_addr = addr_ff;
  assign mem_rd = rd_ff;
  assign link.data = data_ff;
  assign link.shift_load_strobe = load_ff;
  assign link.palette_write_select = palsel_ff;
  assign link.pal_addr = paddr_ff;
  assign link.line_visible_strobe = de_ff;
  assign link.blank = blank_ff;
  assign link.vsync = vs_ff;
endmodule // bvs_memctl

/* File: test/bvs_link_assertions.sv */
// link protocol checks between memory controller and shifter
`timescale 1ns/1ps
module bvs_link_assertions
  import bvs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link signals
  input wire logic [WORD_W-1:0] data,
  input wire logic shift_load_strobe,
  input wire logic palette_write_select,
  input wire logic [PAL_IDX_W-1:0] pal_addr,
  input wire logic line_visible_strobe,
  input wire logic blank,
  input wire logic vsync
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_load_pulse: assert property (shift_load_strobe |=> !shift_load_strobe)
    else $error("load strobe longer than one cycle");
  chk_load_spacing: assert property (shift_load_strobe |=> ##1 !shift_load_strobe)
    else $error("loads closer than one word fetch");
  chk_pal_pulse: assert property (palette_write_select |=> !palette_write_select)
    else $error("palette select longer than one cycle");
  chk_bus_shared: assert property (!(shift_load_strobe && palette_write_select))
    else $error("palette select during a word load");
  chk_load_visible: assert property (shift_load_strobe |-> line_visible_strobe)
    else $error("word loaded outside a visible line");
  chk_line_fetch: assert property ($rose(line_visible_strobe) |->
    ##[1:30] (shift_load_strobe || !line_visible_strobe))
    else $error("visible line without a word load");
  chk_reset_blank: assert property ($fell(rst) |->
    blank && !shift_load_strobe && !palette_write_select)
    else $error("link not quiet and blanked after reset");
  chk_reset_strobes: assert property ($fell(rst) |-> !line_visible_strobe && !vsync)
    else $error("timing strobes active after reset");
  cover property (shift_load_strobe);
  cover property (palette_write_select);
  cover property ($rose(vsync));
endmodule // bvs_link_assertions

/* File: test/test_bitplane_video_shifter.sv */
// self-checking bench: memory controller and shifter joined by the link
`timescale 1ns/1ps
module test_bitplane_video_shifter;
  import bvs_pkg::*;
  typedef struct packed {
    logic [1:0] res;
    logic [ADDR_W-1:0] base;
    logic inv;
    logic [2:0] planes;
    logic [ADDR_W-1:0] addr;
  } bvs_row_t;
  localparam bvs_row_t ROWS [4] = '{
    '{2'h0, 23'h012345, 1'b0, 3'h4, 23'h012300},
    '{2'h1, 23'h0400ff, 1'b0, 3'h2, 23'h040000},
    '{2'h2, 23'h7f8001, 1'b0, 3'h1, 23'h7f8000},
    '{2'h2, 23'h000080, 1'b1, 3'h1, 23'h000000}};
  logic clk, rst, base_wr, pal_wr, disp_enable, disp_blank, disp_vsync, mem_rd, mem_valid;
  logic mono_monitor_detect, mono_attached, mono_out;
  logic [ADDR_W-1:0] base_addr, mem_addr, exp_addr;
  logic [PAL_IDX_W-1:0] pal_index;
  logic [PAL_ENTRY_W-1:0] pal_value;
  logic [PAL_ENTRY_W-1:0] pal [PAL_ENTRIES];
  logic [WORD_W-1:0] mem_rdata;
  logic [WORD_W-1:0] pw [PLANES_MAX];
  logic [LEVEL_W-1:0] red_out, green_out, blue_out;
  logic [1:0] res_sel;
  logic [13:0] snap;
  logic [9:0] exp_px [64];
  logic [9:0] exp_mk [64];
  int mismatches, n_compared, cyc, ncyc, lat, wcnt, gcnt, pl, brun;
  bvs_link_if link ();
  bvs_memctl i_bvs_memctl (.clk(clk), .rst(rst), .base_wr(base_wr), .base_addr(base_addr),
    .pal_wr(pal_wr), .pal_index(pal_index), .pal_value(pal_value), .disp_enable(disp_enable),
    .disp_blank(disp_blank), .disp_vsync(disp_vsync), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .mem_valid(mem_valid), .link(link.memctl));
  bvs_shifter i_bvs_shifter (.clk(clk), .rst(rst), .link(link.shifter), .res_sel(res_sel),
    .mono_monitor_detect(mono_monitor_detect), .mono_attached(mono_attached),
    .red_out(red_out), .green_out(green_out), .blue_out(blue_out), .mono_out(mono_out));
  bvs_link_assertions i_bvs_link_assertions (.clk(clk), .rst(rst), .data(link.data),
    .shift_load_strobe(link.shift_load_strobe), .palette_write_select(link.palette_write_select),
    .pal_addr(link.pal_addr), .line_visible_strobe(link.line_visible_strobe),
    .blank(link.blank), .vsync(link.vsync));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic test_done;
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [ADDR_W-1:0] e, input logic [ADDR_W-1:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_pal(input logic [3:0] i, input logic [8:0] v);
    @(posedge clk);
    pal_wr <= 1;
    pal_index <= i;
    pal_value <= v;
    @(posedge clk);
    pal_wr <= 0;
    pal[i] = v;
    repeat (2) @(posedge clk);
  endtask
  task automatic wr_base(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    base_wr <= 1;
    base_addr <= a;
    @(posedge clk);
    base_wr <= 0;
  endtask
  task automatic frame(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    disp_vsync <= 1;
    repeat (3) @(posedge clk);
    disp_vsync <= 0;
    exp_addr = a;
  endtask
  task automatic line(input int n);
    disp_enable <= 1;
    repeat (n) @(posedge clk);
    disp_enable <= 0;
    repeat (30) @(posedge clk);
  endtask
  // display memory: answers each read after lat cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      mismatches++;
      test_done();
    end
    if (mem_valid) begin
      mem_valid <= 0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_rd) begin
      wcnt = wcnt + 1;
      if (wcnt >= lat) begin
        wcnt = 0;
        mem_valid <= 1;
        mem_rdata <= 16'(mem_addr * 23'h009e37);
        check("mem_addr", exp_addr, mem_addr);
        exp_addr = exp_addr + 2;
      end
    end
  end
  // pixel scoreboard: pixel k of a group shows 3 + k samples after its last load
  always @(negedge clk) begin
    logic [3:0] ix;
    logic [9:0] seen;
    int slot;
    ncyc++;
    if (exp_mk[ncyc % 64] != 0) begin
      seen = {red_out, green_out, blue_out, mono_out} & exp_mk[ncyc % 64];
      if (!link.blank)
        check("pixel", 23'(exp_px[ncyc % 64]), 23'(seen));
      exp_mk[ncyc % 64] = 0;
    end
    brun = link.blank ? brun + 1 : 0;
    if (brun > 3)
      check("blanked", 23'h0, 23'({red_out, green_out, blue_out, mono_out}));
    if (link.vsync || rst)
      gcnt = 0;
    if (link.shift_load_strobe && link.line_visible_strobe) begin
      pw[gcnt] = link.data;
      gcnt++;
      if (gcnt == pl) begin
        gcnt = 0;
        for (int k = 0; k < 16; k++) begin
          ix = {pw[3][15-k], pw[2][15-k], pw[1][15-k], pw[0][15-k]} & (4'(1 << pl) - 4'h1);
          slot = (ncyc + 3 + k) % 64;
          if (pl == 1) begin
            exp_px[slot] = {9'h000, pw[0][15-k] ^ pal[0][0]};
            exp_mk[slot] = 10'h3ff;
          end else begin
            exp_px[slot] = {pal[ix], 1'b0};
            exp_mk[slot] = 10'h3fe;
          end
        end
      end
    end
  end
  initial begin
    {rst, base_wr, pal_wr, disp_enable, disp_blank, disp_vsync, mem_valid} = 7'h40;
    {base_addr, exp_addr, pal_index, pal_value, mem_rdata, res_sel} = '0;
    {mismatches, n_compared, cyc, ncyc, wcnt, gcnt, brun} = '0;
    mono_monitor_detect = 1;
    lat = 3;
    pl = 4;
    foreach (exp_mk[i]) exp_mk[i] = 0;
    repeat (2) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < PAL_ENTRIES; i++) wr_pal(4'(i), 9'(i * 37 + 5));
    foreach (ROWS[r]) begin
      res_sel <= ROWS[r].res;
      pl = int'(ROWS[r].planes);
      lat = 24 / pl - 3;
      wr_pal(4'h0, {pal[0][8:1], ROWS[r].inv});
      wr_base(ROWS[r].base);
      frame(ROWS[r].addr);
      line(70);
    end
    disp_blank <= 1;
    frame(23'h000000);
    line(70);
    disp_blank <= 0;
    mono_monitor_detect <= 0;
    repeat (5) @(posedge clk);
    check("mono_attached", 23'h1, 23'(mono_attached));
    mono_monitor_detect <= 1;
    repeat (5) @(posedge clk);
    check("mono_attached", 23'h0, 23'(mono_attached));
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    @(negedge clk);
    snap = {link.blank, link.shift_load_strobe, link.palette_write_select, red_out, green_out,
      blue_out, mono_out, mono_attached};
    check("reset", 23'h002000, 23'(snap));
    foreach (pal[i]) pal[i] = 0;
    wr_base(23'h000000);
    frame(23'h000000);
    line(70);
    test_done();
  end
endmodule // test_bitplane_video_shifter
